// file: hdl/disk_drive_serial_interface.sv
// Operation
// - NRZ: general input is a branch condition
// - RLL: shared input is write oscillator, 2x
// - General output follows sequencer control field
// - Accept index pulse from drive
// - Sector pin: sector or ones reset
// - Shared output: read gate or RLL data
// - Precompensate encoded data when enabled
// - Open-drain ramp timed by comparator
// - Drive write gate to the drive
// - Serial pin: NRZ both ways, RLL input
// - Mark pin: marks in NRZ, VFO enable
// - Shared clock: reference or doubled VFO
// - Mode bit bypasses 2,7 encoder/decoder
// - Enable bit, early and late delays
`timescale 1ns/1ns
`default_nettype none
`include "disk_if_regs.svh"
module disk_drive_serial_interface
  import disk_if_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             nrz_mode,
  input  wire logic             hard_sector,
  input  wire logic             precomp_enable,
  input  wire logic [7:0]       early_delay,
  input  wire logic [7:0]       late_delay,
  input  wire logic             seq_control_bit,
  input  wire logic             read_enable,
  input  wire logic             write_enable,
  input  wire logic             write_mark_request,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic [WIDTH-1:0]      rd_data,
  output logic                  rd_valid,
  output logic                  branch_condition,
  output logic                  index_pulse,
  output logic                  sector_pulse,
  output logic                  ones_reset_pulse,
  output logic                  mark_detected,
  input  wire logic             write_osc_clock_in,
  input  wire logic             ref_vfo_clock_in,
  input  wire logic             index_in,
  input  wire logic             sector_ones_reset_in,
  output logic                  general_output,
  output logic                  read_gate_or_encoded_out,
  output logic                  precomp_ramp_out,
  output logic                  precomp_ramp_oe,
  input  wire logic             precomp_ramp_sense,
  output logic [7:0]            ramp_threshold,
  output logic                  write_gate,
  input  wire logic             serial_data_in,
  output logic                  serial_data_out,
  output logic                  serial_data_oe,
  input  wire logic             mark_pin_in,
  output logic                  mark_pin_out,
  output logic                  mark_pin_oe
);
  localparam int SI_LINK = 0;
  localparam int SI_OSC  = 1;
  localparam int SI_IDX  = 2;
  localparam int SI_SEC  = 3;
  localparam int SI_DAT  = 4;
  localparam int SI_MARK = 5;
  localparam int SI_RAMP = 6;

  stream_if #(.WIDTH(WIDTH)) fill_s ();
  stream_if #(.WIDTH(WIDTH)) drain_s ();

  logic [6:0]     s1_q, s2_q, s3_q, rise, fall;
  logic           osc_ph_q, osc_ph_d, vfo_ph_q, vfo_ph_d;
  logic           nrz_tick, wch_tick, rch_tick;
  logic [7:0]     dbyte_q, dbyte_d;
  logic [3:0]     dcnt_q, dcnt_d;
  logic           take_bit, enc_want;
  logic [3:0]     pend_q, pend_d;
  logic [2:0]     plen_q, plen_d;
  logic [7:0]     chn_q, chn_d;
  logic [3:0]     chn_len_q, chn_len_d;
  logic [2:0]     hist_q, hist_d;
  enc_word_t      enc;
  precomp_state_t pc_q, pc_d;
  logic [7:0]     thr_q, thr_d, thr_new;
  logic [8:0]     late_sum;
  logic           level_q, level_d, cur_bit;
  logic [7:0]     cacc_q, cacc_d;
  logic [3:0]     clen_q, clen_d;
  dec_word_t      dec;
  logic [3:0]     dq_q, dq_d;
  logic [2:0]     dqn_q, dqn_d;
  logic           rbit_vld, rbit;
  logic [7:0]     rx_q, rx_d;
  logic [3:0]     rcnt_q, rcnt_d;
  logic [WIDTH-1:0] rd_data_d;
  logic           rd_valid_d, sdo_d, rgate_q;

  function automatic enc_word_t enc_match(input logic [3:0] p,
                                          input logic [2:0] n);
    enc_match = '0;
    case (n)
      3'h2: begin
        if (p[1:0] == 2'b10) enc_match = '{1'b1, 8'h40, 4'h4};
        if (p[1:0] == 2'b11) enc_match = '{1'b1, 8'h80, 4'h4};
      end
      3'h3: begin
        if (p[2:0] == 3'b000) enc_match = '{1'b1, 8'h10, 4'h6};
        if (p[2:0] == 3'b010) enc_match = '{1'b1, 8'h90, 4'h6};
        if (p[2:0] == 3'b011) enc_match = '{1'b1, 8'h20, 4'h6};
      end
      3'h4: begin
        if (p == 4'b0010) enc_match = '{1'b1, 8'h24, 4'h8};
        if (p == 4'b0011) enc_match = '{1'b1, 8'h08, 4'h8};
      end
      default: enc_match = '0;
    endcase
  endfunction

  function automatic dec_word_t dec_match(input logic [7:0] a,
                                          input logic [3:0] n);
    dec_match = '0;
    case (n)
      4'h4: begin
        if (a[3:0] == 4'h4) dec_match = '{1'b1, 4'h8, 3'h2};
        if (a[3:0] == 4'h8) dec_match = '{1'b1, 4'hc, 3'h2};
      end
      4'h6: begin
        if (a[5:0] == 6'h04) dec_match = '{1'b1, 4'h0, 3'h3};
        if (a[5:0] == 6'h24) dec_match = '{1'b1, 4'h4, 3'h3};
        if (a[5:0] == 6'h08) dec_match = '{1'b1, 4'h6, 3'h3};
      end
      4'h8: begin
        if (a == 8'h24) dec_match = '{1'b1, 4'h2, 3'h4};
        if (a == 8'h08) dec_match = '{1'b1, 4'h3, 3'h4};
      end
      default: dec_match = '0;
    endcase
  endfunction

  // Pins leave the link domain through two flops; third flop is for edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= `SYNC_RESET_VAL;
      s2_q <= `SYNC_RESET_VAL;
      s3_q <= `SYNC_RESET_VAL;
    end else begin
      s1_q <= {precomp_ramp_sense, mark_pin_in, serial_data_in,
               sector_ones_reset_in, index_in, write_osc_clock_in,
               ref_vfo_clock_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise     = s2_q & ~s3_q;
  assign fall     = ~s2_q & s3_q;
  assign nrz_tick = nrz_mode & rise[SI_LINK];
  // Channel bits run at half the doubled clocks
  assign wch_tick = ~nrz_mode & rise[SI_OSC] & osc_ph_q;
  assign rch_tick = ~nrz_mode & rise[SI_LINK] & vfo_ph_q;
  assign osc_ph_d = rise[SI_OSC] ? ~osc_ph_q : osc_ph_q;
  assign vfo_ph_d = ~rgate_q ? 1'b0 : (rise[SI_LINK] ? ~vfo_ph_q : vfo_ph_q);

  assign fill_s.data  = wr_data;
  assign fill_s.valid = wr_valid;
  assign wr_ready     = fill_s.ready;

  two_entry_buffer #(.WIDTH(WIDTH), .DEPTH(DEPTH)) tx_buf (
    .clk    (clk),
    .resetn (resetn),
    .fill   (fill_s),
    .drain  (drain_s)
  );

  // Transmit bit source, shared by NRZ shifting and the encoder
  assign enc      = enc_match(pend_q, plen_q);
  assign enc_want = ~nrz_mode & write_gate & ~enc.hit
                    & (plen_q < `DATA_WORD_MAX);
  assign take_bit = (dcnt_q != 4'h0)
                    & (nrz_mode ? (write_gate & nrz_tick) : enc_want);
  assign drain_s.ready = (dcnt_q == 4'h0);

  always_comb begin
    dbyte_d = dbyte_q;
    dcnt_d  = dcnt_q;
    sdo_d   = serial_data_out;
    if (drain_s.ready && drain_s.valid) begin
      dbyte_d = drain_s.data[7:0];
      dcnt_d  = `BYTE_BITS;
    end else if (take_bit) begin
      dbyte_d = {dbyte_q[6:0], 1'b0};
      dcnt_d  = dcnt_q - 4'h1;
    end
    if (take_bit && nrz_mode) begin
      sdo_d = dbyte_q[7];
    end
  end

  // Encoder and channel shifter
  assign cur_bit  = chn_q[7];
  assign late_sum = {1'b0, early_delay} + {1'b0, late_delay};

  always_comb begin
    pend_d    = pend_q;
    plen_d    = plen_q;
    chn_d     = chn_q;
    chn_len_d = chn_len_q;
    hist_d    = hist_q;
    if (take_bit && !nrz_mode) begin
      pend_d = {pend_q[2:0], dbyte_q[7]};
      plen_d = plen_q + 3'h1;
    end
    if (enc.hit && chn_len_q == 4'h0) begin
      chn_d     = enc.code;
      chn_len_d = enc.len;
      pend_d    = 4'h0;
      plen_d    = 3'h0;
    end else if (wch_tick && chn_len_q != 4'h0) begin
      chn_d     = {chn_q[6:0], 1'b0};
      chn_len_d = chn_len_q - 4'h1;
      hist_d    = {hist_q[1:0], cur_bit};
    end
    if (!write_gate) begin
      pend_d    = 4'h0;
      plen_d    = 3'h0;
      chn_len_d = 4'h0;
      hist_d    = 3'h0;
    end
  end

  // Early: next one is three slots ahead; late: previous three behind
  always_comb begin
    thr_new = early_delay;
    if (hist_q[2] && !chn_q[4]) begin
      thr_new = late_sum[8] ? 8'hff : late_sum[7:0];
    end else if (chn_q[4] && !hist_q[2]) begin
      thr_new = 8'h00;
    end
  end

  // A one that arrives while a ramp is still running is sent undelayed
  always_comb begin
    pc_d    = pc_q;
    thr_d   = thr_q;
    level_d = level_q;
    if (wch_tick && chn_len_q != 4'h0) begin
      level_d = 1'b0;
    end
    case (pc_q)
      PC_IDLE: begin
        if (wch_tick && chn_len_q != 4'h0 && cur_bit) begin
          if (precomp_enable && thr_new != 8'h00) begin
            pc_d  = PC_RAMP;
            thr_d = thr_new;
          end else begin
            level_d = 1'b1;
          end
        end
      end
      PC_RAMP: begin
        if (s2_q[SI_RAMP]) begin
          pc_d = PC_FIRE;
        end
      end
      PC_FIRE: begin
        level_d = 1'b1;
        pc_d    = PC_DUMP;
      end
      PC_DUMP: begin
        if (!s2_q[SI_RAMP]) begin
          pc_d = PC_IDLE;
        end
      end
      default: pc_d = PC_IDLE;
    endcase
    if (pc_q != PC_IDLE && wch_tick && chn_len_q != 4'h0 && cur_bit) begin
      level_d = 1'b1;
    end
    if (!write_gate) begin
      level_d = 1'b0;
    end
  end

  // Decoder and receive byte assembly
  assign dec = dec_match(cacc_q, clen_q);

  always_comb begin
    cacc_d = cacc_q;
    clen_d = clen_q;
    dq_d   = dq_q;
    dqn_d  = dqn_q;
    if (dqn_q != 3'h0) begin
      dq_d  = {dq_q[2:0], 1'b0};
      dqn_d = dqn_q - 3'h1;
    end
    if (dec.hit) begin
      dq_d   = dec.bits;
      dqn_d  = dec.cnt;
      cacc_d = 8'h00;
      clen_d = 4'h0;
    end else if (clen_q == `CHAN_WORD_MAX) begin
      // Unknown word: drop it and resynchronise on the next bits
      cacc_d = 8'h00;
      clen_d = 4'h0;
    end
    if (rch_tick && rgate_q) begin
      cacc_d = {cacc_d[6:0], s2_q[SI_DAT]};
      clen_d = clen_d + 4'h1;
    end
    if (!rgate_q) begin
      cacc_d = 8'h00;
      clen_d = 4'h0;
      dqn_d  = 3'h0;
    end
  end

  assign rbit_vld = nrz_mode ? (nrz_tick & rgate_q)
                             : (dqn_q != 3'h0);
  assign rbit     = nrz_mode ? s2_q[SI_DAT] : dq_q[3];

  always_comb begin
    rx_d       = rx_q;
    rcnt_d     = rcnt_q;
    rd_data_d  = rd_data;
    rd_valid_d = 1'b0;
    if (rbit_vld) begin
      rx_d   = {rx_q[6:0], rbit};
      rcnt_d = rcnt_q + 4'h1;
      if (rcnt_q == `BYTE_BITS - 4'h1) begin
        rd_data_d  = WIDTH'({rx_q[6:0], rbit});
        rd_valid_d = 1'b1;
        rcnt_d     = 4'h0;
      end
    end
    if (!rgate_q) begin
      rcnt_d = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_ph_q  <= 1'b0;
      vfo_ph_q  <= 1'b0;
      dbyte_q   <= 8'h00;
      dcnt_q    <= 4'h0;
      pend_q    <= 4'h0;
      plen_q    <= 3'h0;
      chn_q     <= 8'h00;
      chn_len_q <= 4'h0;
      hist_q    <= 3'h0;
      pc_q      <= PC_IDLE;
      thr_q     <= `THRESHOLD_RESET;
      level_q   <= 1'b0;
      cacc_q    <= 8'h00;
      clen_q    <= 4'h0;
      dq_q      <= 4'h0;
      dqn_q     <= 3'h0;
      rx_q      <= 8'h00;
      rcnt_q    <= 4'h0;
    end else begin
      osc_ph_q  <= osc_ph_d;
      vfo_ph_q  <= vfo_ph_d;
      dbyte_q   <= dbyte_d;
      dcnt_q    <= dcnt_d;
      pend_q    <= pend_d;
      plen_q    <= plen_d;
      chn_q     <= chn_d;
      chn_len_q <= chn_len_d;
      hist_q    <= hist_d;
      pc_q      <= pc_d;
      thr_q     <= thr_d;
      level_q   <= level_d;
      cacc_q    <= cacc_d;
      clen_q    <= clen_d;
      dq_q      <= dq_d;
      dqn_q     <= dqn_d;
      rx_q      <= rx_d;
      rcnt_q    <= rcnt_d;
    end
  end

  // Output pins and pulses, all registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rgate_q                  <= 1'b0;
      rd_data                  <= '0;
      rd_valid                 <= 1'b0;
      branch_condition         <= 1'b0;
      index_pulse              <= 1'b0;
      sector_pulse             <= 1'b0;
      ones_reset_pulse         <= 1'b0;
      mark_detected            <= 1'b0;
      general_output           <= 1'b0;
      read_gate_or_encoded_out <= 1'b0;
      precomp_ramp_out         <= 1'b0;
      precomp_ramp_oe          <= 1'b1;
      ramp_threshold           <= `THRESHOLD_RESET;
      write_gate               <= 1'b0;
      serial_data_out          <= 1'b0;
      serial_data_oe           <= 1'b0;
      mark_pin_out             <= `MARK_PIN_IDLE;
      mark_pin_oe              <= 1'b0;
    end else begin
      rgate_q          <= read_enable;
      rd_data          <= rd_data_d;
      rd_valid         <= rd_valid_d;
      branch_condition <= nrz_mode & s2_q[SI_OSC];
      index_pulse      <= rise[SI_IDX];
      sector_pulse     <= hard_sector & rise[SI_SEC];
      ones_reset_pulse <= ~hard_sector & rise[SI_SEC];
      mark_detected    <= nrz_mode & ~write_gate & fall[SI_MARK];
      general_output   <= seq_control_bit;
      read_gate_or_encoded_out <= nrz_mode ? read_enable : level_d;
      precomp_ramp_out <= 1'b0;
      // Ramp is held discharged except while timing a delay
      precomp_ramp_oe  <= (pc_d != PC_RAMP);
      ramp_threshold   <= thr_d;
      write_gate       <= write_enable;
      serial_data_out  <= sdo_d;
      serial_data_oe   <= nrz_mode & write_enable;
      mark_pin_out     <= nrz_mode ? ~write_mark_request : read_enable;
      mark_pin_oe      <= ~nrz_mode | write_enable;
    end
  end
endmodule
`default_nettype wire

// file: hdl/disk_if_regs.svh
`ifndef DISK_IF_REGS_SVH
`define DISK_IF_REGS_SVH

// Ramp step as a fraction of the external RC, in thousandths
`define PRECOMP_STEP_PERMILLE 50
`define SYNC_RESET_VAL        7'h00
`define BYTE_BITS             4'h8
`define CHAN_WORD_MAX         4'h8
`define DATA_WORD_MAX         3'h4
`define MARK_PIN_IDLE         1'b1
`define THRESHOLD_RESET       8'h00

`endif

// file: hdl/disk_if_pkg.sv
package disk_if_pkg;

  typedef enum logic [3:0] {
    PC_IDLE = 4'b0001,
    PC_RAMP = 4'b0010,
    PC_FIRE = 4'b0100,
    PC_DUMP = 4'b1000
  } precomp_state_t;

  typedef struct packed {
    logic       hit;
    logic [7:0] code;
    logic [3:0] len;
  } enc_word_t;

  typedef struct packed {
    logic       hit;
    logic [3:0] bits;
    logic [2:0] cnt;
  } dec_word_t;

endpackage

// file: hdl/stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// file: hdl/two_entry_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic resetn,
  stream_if.snk    fill,
  stream_if.src    drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             rdy_q, rdy_d;
  logic             push, pop;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == LAST) ? '0 : PW'(p + 1'b1);
  endfunction

  assign fill.ready  = rdy_q;
  assign drain.valid = (cnt_q != '0);
  assign drain.data  = mem_q[rp_q];
  assign push        = fill.valid & rdy_q;
  assign pop         = drain.valid & drain.ready;

  always_comb begin
    mem_d = mem_q;
    if (push) begin
      mem_d[wp_q] = fill.data;
    end
    wp_d  = push ? step(wp_q) : wp_q;
    rp_d  = pop ? step(rp_q) : rp_q;
    cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    // Registered ready keeps the fill side free of a combinational path
    rdy_d = (cnt_d != FULL);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end
endmodule
`default_nettype wire

// file: sim/disk_if_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module disk_if_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic nrz_mode,
  input wire logic hard_sector,
  input wire logic seq_control_bit,
  input wire logic read_enable,
  input wire logic write_enable,
  input wire logic write_mark_request,
  input wire logic write_osc_clock_in,
  input wire logic index_in,
  input wire logic sector_ones_reset_in,
  input wire logic general_output,
  input wire logic read_gate_or_encoded_out,
  input wire logic write_gate,
  input wire logic serial_data_oe,
  input wire logic mark_pin_out,
  input wire logic mark_pin_oe,
  input wire logic branch_condition,
  input wire logic index_pulse,
  input wire logic sector_pulse,
  input wire logic ones_reset_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Gates $past until it sees post-reset samples
  logic live_q;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) live_q <= 1'b0;
    else live_q <= 1'b1;
  sequence s_gen_steady;
    (nrz_mode && $stable(write_osc_clock_in)) [*5];
  endsequence
  sequence s_quiet(sig);
    !sig [*8];
  endsequence
  property p_gen_out;
    live_q |-> general_output == $past(seq_control_bit);
  endproperty
  a_gen_out: assert property (p_gen_out)
    else $error("general output lag");
  property p_wgate;
    live_q |-> write_gate == $past(write_enable);
  endproperty
  a_wgate: assert property (p_wgate)
    else $error("write gate lag");
  property p_rgate;
    live_q && $past(nrz_mode) |->
      read_gate_or_encoded_out == $past(read_enable);
  endproperty
  a_rgate: assert property (p_rgate)
    else $error("read gate lag");
  property p_soe;
    live_q |-> serial_data_oe == $past(nrz_mode && write_enable);
  endproperty
  a_soe: assert property (p_soe)
    else $error("data pin direction");
  property p_mark_nrz;
    live_q && $past(nrz_mode) |-> mark_pin_oe == $past(write_enable) &&
      (!mark_pin_oe || mark_pin_out == !$past(write_mark_request));
  endproperty
  a_mark_nrz: assert property (p_mark_nrz)
    else $error("mark pin in nrz");
  property p_mark_rll;
    live_q && !$past(nrz_mode) |->
      mark_pin_oe && mark_pin_out == $past(read_enable);
  endproperty
  a_mark_rll: assert property (p_mark_rll)
    else $error("vfo enable");
  property p_branch;
    s_gen_steady |-> branch_condition == write_osc_clock_in;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch input");
  property p_branch_rll;
    !nrz_mode [*3] |-> !branch_condition;
  endproperty
  a_branch_rll: assert property (p_branch_rll)
    else $error("branch in rll");
  property p_idx;
    index_pulse |-> $past(index_in, 3) && !$past(index_in, 5)
      ##1 s_quiet(index_pulse);
  endproperty
  a_idx: assert property (p_idx)
    else $error("index pulse");
  property p_sec;
    sector_pulse |-> hard_sector && $past(sector_ones_reset_in, 3) &&
      !$past(sector_ones_reset_in, 5) ##1 s_quiet(sector_pulse);
  endproperty
  a_sec: assert property (p_sec)
    else $error("sector pulse");
  property p_one;
    ones_reset_pulse |-> !hard_sector && $past(sector_ones_reset_in, 3)
      ##1 s_quiet(ones_reset_pulse);
  endproperty
  a_one: assert property (p_one)
    else $error("ones reset pulse");
endmodule
`default_nettype wire

// file: sim/disk_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
module disk_drive_model (
  input  wire logic       clk,
  input  wire logic       link_run,
  input  wire logic       osc_run,
  input  wire logic       gen_level,
  input  wire logic [7:0] tx_byte,
  input  wire logic       sd_oe,
  input  wire logic       sd_out,
  input  wire logic       ramp_oe,
  input  wire logic [7:0] thr,
  output logic            link_clk,
  output logic            osc_pin,
  output logic            sd_wire,
  output logic            sense
);
  logic       osc_q;
  logic [2:0] idx = 3'h7;
  logic [8:0] lvl = 9'h000;
  // Odd offsets keep both clocks out of phase with clk
  initial begin
    link_clk = 1'b0;
    #7;
    forever #200 link_clk = link_run & ~link_clk;
  end
  initial begin
    osc_q = 1'b0;
    #13;
    forever #200 osc_q = osc_run & ~osc_q;
  end
  assign osc_pin = osc_run ? osc_q : gen_level;
  always @(negedge link_clk or negedge link_run)
    if (!link_run) idx <= 3'h7;
    else idx <= idx - 3'h1;
  // Idle line shows the inverted bit, never a stale copy
  assign sd_wire = sd_oe ? sd_out
                 : (link_run ? tx_byte[idx] : ~tx_byte[idx]);
  always @(posedge clk)
    lvl <= ramp_oe ? 9'h000 : lvl + 9'h001;
  assign sense = lvl > {1'b0, thr};
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       clk, resetn, nrz_mode, hard_sector, precomp_enable, ok, s0;
  logic [7:0] early_delay, late_delay, wr_data, rd_data, ramp_threshold;
  logic [7:0] tx_byte, thr_seen, wbits, got;
  logic       seq_control_bit, read_enable, write_enable, write_mark_request;
  logic       wr_valid, wr_ready, rd_valid, branch_condition, index_pulse;
  logic       sector_pulse, ones_reset_pulse, mark_detected, index_in;
  logic       write_osc_clock_in, ref_vfo_clock_in, sector_ones_reset_in;
  logic       general_output, read_gate_or_encoded_out, precomp_ramp_out;
  logic       precomp_ramp_oe, precomp_ramp_sense, write_gate, serial_data_in;
  logic       serial_data_out, serial_data_oe, mark_pin_in, mark_pin_out;
  logic       mark_pin_oe, link_run, osc_run, gen_level, mark_far, enc_q;
  logic       oe_low_seen;
  int         error_cnt, checked, n_idx, n_sec, n_one, n_mark, n_rise, acc;
  disk_drive_serial_interface i_disk_drive_serial_interface (.*);
  disk_drive_model i_disk_drive_model (
    .clk(clk), .link_run(link_run), .osc_run(osc_run), .gen_level(gen_level),
    .tx_byte(tx_byte), .sd_oe(serial_data_oe), .sd_out(serial_data_out),
    .ramp_oe(precomp_ramp_oe), .thr(ramp_threshold),
    .link_clk(ref_vfo_clock_in), .osc_pin(write_osc_clock_in),
    .sd_wire(serial_data_in), .sense(precomp_ramp_sense));
  // Open-drain mark line with pull-up
  assign mark_pin_in = mark_pin_oe ? mark_pin_out : mark_far;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(negedge clk) begin
    if (index_pulse === 1'b1) n_idx++;
    if (sector_pulse === 1'b1) n_sec++;
    if (ones_reset_pulse === 1'b1) n_one++;
    if (mark_detected === 1'b1) n_mark++;
    if (precomp_ramp_oe === 1'b0) begin
      oe_low_seen = 1'b1;
      thr_seen = ramp_threshold;
    end
    if (read_gate_or_encoded_out === 1'b1 && enc_q === 1'b0) n_rise++;
    enc_q <= read_gate_or_encoded_out;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Ready seen at a negedge means the next posedge takes the byte
  task automatic push(input logic [7:0] b, output logic taken);
    wr_data = b;
    wr_valid = 1'b1;
    taken = 1'b0;
    for (int k = 0; k < 6 && !taken; k++) begin
      taken = (wr_ready === 1'b1);
      @(negedge clk);
    end
  endtask
  task automatic wait_rd(output logic [7:0] b);
    for (int k = 0; k < 400 && rd_valid !== 1'b1; k++) @(negedge clk);
    // A byte that never arrives counts as an error; b still takes the stale rd_data
    if (rd_valid !== 1'b1) error_cnt++;
    b = rd_data;
    @(negedge clk);
  endtask
  task automatic pin_pulse(input int which);
    if (which == 0) index_in = 1'b1;
    else sector_ones_reset_in = 1'b1;
    cyc(20);
    {index_in, sector_ones_reset_in} = 2'b00;
    cyc(20);
  endtask
  initial begin
    {resetn, precomp_enable, seq_control_bit, read_enable} = 4'h0;
    {write_enable, write_mark_request, wr_valid, index_in} = 4'h0;
    {sector_ones_reset_in, link_run, osc_run, gen_level} = 4'h0;
    {nrz_mode, hard_sector, mark_far, enc_q, oe_low_seen} = 5'b11100;
    {early_delay, late_delay, wr_data, tx_byte} = 32'h0;
    cyc(2);
    check({precomp_ramp_out, precomp_ramp_oe}, 8'h01);
    check(mark_pin_out, 8'h01);
    check({write_gate, wr_ready, general_output}, 8'h00);
    cyc(2);
    resetn = 1'b1;
    cyc(1);
    // Ready is registered from the empty count, so it rises at once
    check(wr_ready, 8'h01);
    cyc(1);
    check(wr_ready, 8'h01);
    seq_control_bit = 1'b1;
    cyc(1);
    check(general_output, 8'h01);
    gen_level = 1'b1;
    cyc(6);
    check(branch_condition, 8'h01);
    gen_level = 1'b0;
    cyc(6);
    check(branch_condition, 8'h00);
    mark_far = 1'b0;
    cyc(8);
    mark_far = 1'b1;
    check(8'(n_mark), 8'h01);
    pin_pulse(0);
    pin_pulse(1);
    hard_sector = 1'b0;
    pin_pulse(1);
    check(8'(n_idx), 8'h01);
    check({4'(n_sec), 4'(n_one)}, 8'h11);
    read_enable = 1'b1;
    tx_byte = 8'ha5;
    cyc(2);
    link_run = 1'b1;
    repeat (2) begin
      wait_rd(got);
      check(got, 8'ha5);
    end
    {link_run, read_enable} = 2'b00;
    cyc(20);
    ok = 1'b1;
    for (int i = 0; i < 5 && ok; i++) begin
      push(8'hb4 + 8'(i), ok);
      if (ok) acc++;
    end
    wr_valid = 1'b0;
    check(acc >= 2 && acc < 5, 8'h01);
    write_enable = 1'b1;
    cyc(4);
    s0 = serial_data_in;
    link_run = 1'b1;
    repeat (8) begin
      @(posedge ref_vfo_clock_in);
      cyc(6);
      wbits = {wbits[6:0], serial_data_in};
    end
    check(wbits === 8'hb4 || {s0, wbits[7:1]} === 8'hb4, 8'h01);
    cyc(400);
    check(wr_ready, 8'h01);
    write_mark_request = 1'b1;
    cyc(2);
    check({mark_pin_oe, mark_pin_out}, 8'h02);
    write_mark_request = 1'b0;
    {link_run, nrz_mode} = 2'b00;
    {early_delay, late_delay} = 16'h0404;
    for (int p = 0; p < 2; p++) begin
      precomp_enable = p[0];
      push(8'hff, ok);
      push(8'hff, ok);
      wr_valid = 1'b0;
      {n_rise, oe_low_seen} = 0;
      osc_run = 1'b1;
      cyc(900);
      osc_run = 1'b0;
      check(8'(n_rise), 8'h08);
      check(oe_low_seen, 8'(p));
      check(branch_condition, 8'h00);
    end
    check(thr_seen === 8'h04 || thr_seen === 8'h08, 8'h01);
    // Only every second line bit is a channel bit: 1000 repeated
    {tx_byte, read_enable} = {8'h40, 1'b1};
    cyc(2);
    check({mark_pin_oe, mark_pin_out}, 8'h03);
    link_run = 1'b1;
    wait_rd(got);
    check(got, 8'hff);
    link_run = 1'b0;
    report_and_stop;
  end
  initial begin
    #600000;
    error_cnt++;
    report_and_stop;
  end
endmodule
bind disk_drive_serial_interface disk_if_asserts i_disk_if_asserts (.*);
`default_nettype wire
